// ---- logic/exec_params.svh ----
// constants for the three-instruction execute block
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH
`define OP_WIDTH 14
`define DATA_WIDTH 8
`define ADDR_WIDTH 7
`define LIT_TOP_MASK 6'h3c
`define LIT_TOP_CODE 6'h30
`define FILE_TOP_MASK 6'h3f
`define COPY_TOP_CODE 6'h08
`define OR_TOP_CODE 6'h04
`define DIR_BIT 7
`define TOP_LSB 8
`define ACC_RESET 8'h00
`endif

// ---- logic/exec_pkg.sv ----
// types shared by the execute block
package exec_pkg;
    typedef enum logic [1:0] {q_decode, q_read, q_process, q_write} quarter_t;
    typedef enum logic [1:0] {op_none, op_literal, op_copy, op_or} opcode_t;
    typedef struct packed {
        logic [7:0] data;
        logic [6:0] addr;
        logic we;
    } file_write_t;
endpackage

// ---- logic/move_or_instruction_exec.sv ----
// execute unit for literal load, file copy and or-into-file
// Operation
// [RULE1] literal load puts 8-bit immediate into accumulator, flags untouched
// [RULE2] two don't-care bits of literal load opcode are ignored
// [RULE3] file copy reads file register, direction zero sends it to accumulator
// [RULE4] file copy direction one writes value back, accumulator untouched
// [RULE5] file copy sets zero flag from moved value either way
// [RULE6] literal load: decode, read literal, process, write accumulator
// [RULE7] file copy: decode, read file, process, write destination in quarter four; code sends a file write on file_wr.we in the next decode quarter
// [RULE8] or-into-file ors accumulator and file, direction picks destination, sets zero
`timescale 1ns/1ns
`include "exec_params.svh"
module move_or_instruction_exec (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [`OP_WIDTH-1:0] instr,
    input wire logic [`DATA_WIDTH-1:0] file_rdata,
    input wire logic zero_in,
    output logic [`ADDR_WIDTH-1:0] file_addr,
    output exec_pkg::file_write_t file_wr,
    output logic [`DATA_WIDTH-1:0] accumulator,
    output logic zero_flag,
    output logic zero_we,
    output exec_pkg::quarter_t quarter,
    output logic instr_done
);
    // decoder outputs, valid while the word is presented
    exec_pkg::opcode_t dec_op;
    logic dec_dir;
    logic [`ADDR_WIDTH-1:0] dec_addr;
    logic [`DATA_WIDTH-1:0] dec_lit;

    // instruction kind and direction held for the whole slot
    exec_pkg::opcode_t op;
    logic dir;

    // operand from literal or file, and the processed result
    logic [`DATA_WIDTH-1:0] operand;
    logic [`DATA_WIDTH-1:0] result;

    // next quarter of the sequencer
    exec_pkg::quarter_t next_quarter;

    // bit patterns stay in the decoder, sequencing stays here
    opcode_decoder u_dec (
        .instr(instr),
        .op(dec_op),
        .dir(dec_dir),
        .addr(dec_addr),
        .literal(dec_lit)
    );

    // true when the accumulator takes the result
    function automatic logic acc_target(input exec_pkg::opcode_t kind, input logic dir_bit);
        logic hit;
        hit = 1'b0;
        case (kind)
            exec_pkg::op_literal: hit = 1'b1; // [RULE1]
            exec_pkg::op_copy: hit = !dir_bit; // [RULE3]
            exec_pkg::op_or: hit = !dir_bit; // [RULE8]
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // true when the addressed file register takes the result
    function automatic logic file_target(input exec_pkg::opcode_t kind, input logic dir_bit);
        logic hit;
        hit = 1'b0;
        case (kind)
            exec_pkg::op_copy: hit = dir_bit; // [RULE4]
            exec_pkg::op_or: hit = dir_bit; // [RULE8]
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // true when the instruction updates the zero flag
    function automatic logic zero_target(input exec_pkg::opcode_t kind);
        logic hit;
        hit = 1'b0;
        case (kind)
            exec_pkg::op_copy: hit = 1'b1; // [RULE5]
            exec_pkg::op_or: hit = 1'b1; // [RULE8]
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // processing step: or with accumulator, otherwise pass through
    function automatic logic [`DATA_WIDTH-1:0] combine(
        input exec_pkg::opcode_t kind,
        input logic [`DATA_WIDTH-1:0] value,
        input logic [`DATA_WIDTH-1:0] acc_value
    );
        logic [`DATA_WIDTH-1:0] out;
        out = value;
        if (kind == exec_pkg::op_or) begin
            out = value | acc_value; // [RULE8]
        end
        return out;
    endfunction

    // destination and flag selection for the slot in flight
    wire [`DATA_WIDTH-1:0] next_result = combine(op, operand, accumulator); // [RULE8]
    wire to_acc = acc_target(op, dir); // [RULE3]
    wire to_file = file_target(op, dir); // [RULE4]
    wire sets_zero = zero_target(op); // [RULE5]

    // quarter qualifiers
    wire in_decode = quarter == exec_pkg::q_decode;
    wire in_read = quarter == exec_pkg::q_read;
    wire in_process = quarter == exec_pkg::q_process;
    wire in_write = quarter == exec_pkg::q_write;

    // strobes for each register update
    wire take_file = in_read && (op != exec_pkg::op_literal); // [RULE7]
    wire acc_load = in_write && to_acc; // [RULE6]
    wire file_store = in_write && to_file; // [RULE4]
    wire zero_store = in_write && sets_zero; // [RULE5]
    wire result_zero = result == '0;

    // quarter order: decode, read, process, write
    always_comb begin
        next_quarter = exec_pkg::q_decode;
        case (quarter)
            exec_pkg::q_decode: next_quarter = exec_pkg::q_read; // [RULE6] [RULE7]
            exec_pkg::q_read: next_quarter = exec_pkg::q_process;
            exec_pkg::q_process: next_quarter = exec_pkg::q_write;
            default: next_quarter = exec_pkg::q_decode;
        endcase
    end

    // quarter sequencer: one instruction per four clocks
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            quarter <= exec_pkg::q_decode;
        end else begin
            quarter <= next_quarter;
        end
    end

    // instruction kind latched at decode
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            op <= exec_pkg::op_none;
        end else if (in_decode) begin
            op <= dec_op; // [RULE2]
        end
    end

    // direction bit latched at decode
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dir <= 1'b0;
        end else if (in_decode) begin
            dir <= dec_dir;
        end
    end

    // file address held for read and write-back
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            file_addr <= '0;
        end else if (in_decode) begin
            file_addr <= dec_addr;
        end
    end

    // operand: literal at decode, file data in read quarter
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            operand <= '0;
        end else if (in_decode) begin
            operand <= dec_lit; // [RULE6]
        end else if (take_file) begin
            operand <= file_rdata; // [RULE7]
        end
    end

    // result registered in process quarter
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            result <= '0;
        end else if (in_process) begin
            result <= next_result;
        end
    end

    // accumulator written at the end of the write quarter
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            accumulator <= `ACC_RESET;
        end else if (acc_load) begin
            accumulator <= result; // [RULE1] [RULE6]
        end
    end

    // file write request, one-cycle strobe
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            file_wr <= '0;
        end else begin
            file_wr.we <= file_store; // [RULE4] [RULE7]
            file_wr.addr <= file_addr;
            file_wr.data <= result;
        end
    end

    // zero flag write strobe
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            zero_we <= 1'b0;
        end else begin
            zero_we <= zero_store; // [RULE5]
        end
    end

    // zero flag: own result when written, core status otherwise
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            zero_flag <= 1'b0;
        end else if (zero_store) begin
            zero_flag <= result_zero; // [RULE5]
        end else if (!zero_we) begin
            zero_flag <= zero_in; // status kept by core otherwise
        end
    end

    // end of slot marker
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            instr_done <= 1'b0;
        end else begin
            instr_done <= in_write;
        end
    end
endmodule

// ---- logic/opcode_decoder.sv ----
// combinational decode of the instruction word
`timescale 1ns/1ns
`include "exec_params.svh"
module opcode_decoder (
    input wire logic [`OP_WIDTH-1:0] instr,
    output exec_pkg::opcode_t op,
    output logic dir,
    output logic [`ADDR_WIDTH-1:0] addr,
    output logic [`DATA_WIDTH-1:0] literal
);
    wire [5:0] top = instr[`OP_WIDTH-1:`TOP_LSB];
    // don't-care bits masked out of the literal pattern
    wire is_lit = (top & `LIT_TOP_MASK) == `LIT_TOP_CODE; // [RULE1] [RULE2]
    wire is_copy = (top & `FILE_TOP_MASK) == `COPY_TOP_CODE; // [RULE3]
    wire is_or = (top & `FILE_TOP_MASK) == `OR_TOP_CODE; // [RULE8]
    assign op = is_lit ? exec_pkg::op_literal : is_copy ? exec_pkg::op_copy :
        is_or ? exec_pkg::op_or : exec_pkg::op_none;
    assign dir = instr[`DIR_BIT];
    assign addr = instr[`ADDR_WIDTH-1:0];
    assign literal = instr[`DATA_WIDTH-1:0];
endmodule

// ---- verif/exec_monitor.sv ----
// port checker for the execute block
`timescale 1ns/1ns
module exec_monitor (
    input logic sys_clk,
    input logic rst_n,
    input logic [13:0] instr,
    input logic [7:0] file_rdata,
    input logic [7:0] accumulator,
    input exec_pkg::file_write_t file_wr,
    input logic zero_flag,
    input logic zero_we,
    input exec_pkg::quarter_t quarter,
    input logic instr_done
);
    logic [13:0] iw;
    logic [7:0] rw, aw;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // word, file data and accumulator of the slot in flight
    always_ff @(posedge sys_clk) if (quarter == 2'h2) {iw, rw, aw} <= {$past(instr, 2), $past(file_rdata), accumulator};
    property p_seq; quarter == 2'h3 |=> quarter == 2'h0 ##1 quarter == 2'h1; endproperty
    a_seq: assert property (p_seq) else $error("order");
    property p_slot; file_wr.we || zero_we |-> instr_done && quarter == 2'h0; endproperty
    a_slot: assert property (p_slot) else $error("slot");
    property p_lit; instr_done && iw[13:10] == 4'hc |-> !zero_we && accumulator == iw[7:0]; endproperty
    a_lit: assert property (p_lit) else $error("lit");
    property p_dc; instr_done && iw[13:8] inside {6'h31, 6'h32, 6'h33} |-> accumulator == iw[7:0]; endproperty
    a_dc: assert property (p_dc) else $error("dc");
    property p_mv0; instr_done && iw[13:7] == 7'h10 |-> accumulator == rw; endproperty
    a_mv0: assert property (p_mv0) else $error("mv0");
    property p_mv1; instr_done && iw[13:7] == 7'h11 |-> file_wr == {rw, iw[6:0], 1'b1} && $stable(accumulator); endproperty
    a_mv1: assert property (p_mv1) else $error("mv1");
    property p_z; instr_done && iw[13:8] == 6'h08 |-> zero_we && zero_flag == (rw == 8'h00); endproperty
    a_z: assert property (p_z) else $error("z");
    property p_or; instr_done && iw[13:8] == 6'h04 |-> zero_we && (iw[7] ? file_wr.data : accumulator) == (aw | rw); endproperty
    a_or: assert property (p_or) else $error("or");
endmodule
bind move_or_instruction_exec exec_monitor u_mon (.sys_clk, .rst_n, .instr, .file_rdata, .accumulator,
    .file_wr, .zero_flag, .zero_we, .quarter, .instr_done);

// ---- verif/file_array_model.sv ----
// file register array model
`timescale 1ns/1ns
module file_array_model (
    input logic sys_clk,
    input logic [6:0] file_addr,
    input exec_pkg::file_write_t file_wr,
    output logic [7:0] file_rdata
);
    logic [7:0] mem [128] = '{default: 8'h00};
    // read follows the address, writes land at the clock
    assign file_rdata = mem[file_addr];
    always @(posedge sys_clk) if (file_wr.we) mem[file_wr.addr] <= file_wr.data;
endmodule

// ---- verif/move_or_instruction_exec_tb.sv ----
// self-checking bench for the execute block
`timescale 1ns/1ns
module move_or_instruction_exec_tb;
    logic sys_clk = 0, rst_n = 0, zero_in = 0, zero_flag, zero_we, instr_done;
    logic [13:0] instr = 14'h3fff;
    logic [7:0] file_rdata, accumulator;
    logic [6:0] file_addr;
    exec_pkg::file_write_t file_wr;
    exec_pkg::quarter_t quarter;
    int fails = 0, comparisons = 0, acc = 0, k, a, d, v, mem [128];
    logic [25:0] q [$];
    move_or_instruction_exec u_dut (.sys_clk, .rst_n, .instr, .file_rdata, .zero_in, .file_addr, .file_wr,
        .accumulator, .zero_flag, .zero_we, .quarter, .instr_done);
    file_array_model u_files (.sys_clk, .file_addr, .file_wr, .file_rdata);
    initial forever #20 sys_clk = ~sys_clk;
    task automatic check(input logic [25:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // compare each finished instruction with the model
    always @(posedge sys_clk) #1 if (instr_done === 1'b1 && q.size() > 0)
        check({accumulator, file_wr.we ? 16'(file_wr) : 16'h0, zero_we, zero_flag & zero_we}, q.pop_front());
    initial #40000 begin
        fails++;
        wrap_up();
    end
    // random back-to-back instructions, one per decode slot
    initial begin
        void'($urandom(32'h04c0));
        repeat (12) @(posedge sys_clk);
        #2 rst_n = 1;
        repeat (90) begin
            while (quarter !== 2'h0) @(posedge sys_clk) #2;
            k = $urandom % 3;
            a = $urandom & 97;
            d = $urandom % 2;
            v = ($urandom % 4) ? $urandom % 256 : 0;
            zero_in = 1'($urandom);
            if (k == 0) acc = v;
            else begin
                v = mem[a] | (k == 2 ? acc : 0);
                if (d) mem[a] = v;
                else acc = v;
            end
            instr = k == 0 ? {4'hc, 2'($urandom), 8'(v)} : {k == 1 ? 6'h08 : 6'h04, 1'(d), 7'(a)};
            q.push_back({8'(acc), k > 0 && d ? {8'(v), 7'(a), 1'b1} : 16'h0, k > 0, k > 0 && v == 0});
            @(posedge sys_clk) #2;
        end
        instr = 14'h3fff;
        repeat (8) @(posedge sys_clk);
        check(26'(q.size()), 26'h0);
        wrap_up();
    end
endmodule
